// ### rtl/cyclic_start_safety_control.sv
// What this block does
// RQ1: outputs stay open until required interruptions counted
// RQ2: after count, start press with clear field releases
// RQ3: reset switch opening opens the outputs
// RQ4: interruptions ignored while reset switch is open
// RQ5: after switch closes, counted interruptions auto-release
// RQ6: interruption during movement opens outputs at once
// RQ7: after such stop, recount then start press
// RQ8: cyclic mode only for mode families 66xx, EExx
// RQ9: one cycle is one interrupt then clear
// RQ10: monitoring timeout restarts the whole sequence
// RQ11: counter cleared whenever the outputs open
`timescale 1ns/100ps
`default_nettype none
`include "cssc_regs.svh"
module cyclic_start_safety_control #(
  parameter int          REQ_CYCLES    = `CSSC_REQ_CYCLES,
  parameter int unsigned RESET_OPEN_CYC = `CSSC_RESET_OPEN_CYC,
  parameter int unsigned MONITOR_CYC   = `CSSC_MONITOR_CYC
) (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire cssc_pkg::cssc_mode_t modeCode,
  input  wire logic              fieldClear,
  input  wire logic              startButton,
  input  wire logic              cycleResetClosed,
  output var  logic              safetySwitchingOutput,
  output var  logic              cyclicActive,
  output var  logic [3:0]        cycleCount
);
  import cssc_pkg::*;

  function automatic logic isCyclicMode(input cssc_mode_t m);
    return (m[15:8] == `CSSC_MODE_FAM_A) || (m[15:8] == `CSSC_MODE_FAM_B);
  endfunction

  cssc_state_e state;
  logic        fieldClearQ;
  logic        startQ;
  logic        autoStart;
  logic [31:0] openTimer;
  logic [31:0] monTimer;
  logic        switchLocked;
  logic        cycleDone;
  logic        startEdge;
  logic        monExpired;
  logic        reqMet;
  // set by a stop on a field break: its own clearing is not a counted cycle
  logic        breakSkip;

  //////////////////////////////////////////////////////////////////////////
  assign cyclicActive = isCyclicMode(modeCode); // RQ8
  assign cycleDone    = fieldClear && !fieldClearQ; // RQ9
  assign startEdge    = startButton && !startQ;
  assign monExpired   = (monTimer >= MONITOR_CYC); // RQ10
  assign reqMet       = (cycleCount >= 4'(REQ_CYCLES));

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fieldClearQ <= 1'b1;
      startQ      <= 1'b0;
    end else begin
      fieldClearQ <= fieldClear;
      startQ      <= startButton;
    end
  end

  // switch must stay open the least time before counting resumes
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      openTimer    <= 32'h0;
      switchLocked <= 1'b0;
    end else if (!cycleResetClosed) begin
      switchLocked <= 1'b1; // RQ4
      if (openTimer < RESET_OPEN_CYC) begin
        openTimer <= openTimer + 32'h1;
      end
    end else begin
      if (openTimer >= RESET_OPEN_CYC) begin
        switchLocked <= 1'b0;
      end
      openTimer <= 32'h0;
    end
  end

  // monitoring time between steps
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      monTimer <= 32'h0;
    end else if (state == CSSC_RUN || cycleCount == 4'h0 || cycleDone || startEdge) begin
      monTimer <= 32'h0;
    end else if (!monExpired) begin
      monTimer <= monTimer + 32'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state      <= CSSC_IDLE;
      cycleCount <= 4'h0;
      autoStart  <= 1'b0;
      breakSkip  <= 1'b0;
    end else if (!cyclicActive) begin
      state      <= CSSC_IDLE;
      cycleCount <= 4'h0;
      autoStart  <= 1'b0;
      breakSkip  <= 1'b0;
    end else begin
      case (state)
        CSSC_IDLE: begin
          state <= CSSC_ARMED;
        end
        CSSC_ARMED: begin
          if (monExpired) begin
            cycleCount <= 4'h0; // RQ10
            autoStart  <= 1'b0;
          end else if (cycleDone && breakSkip) begin
            breakSkip <= 1'b0; // RQ7
          end else if (cycleDone && !switchLocked && cycleResetClosed && !reqMet) begin
            cycleCount <= cycleCount + 4'h1; // RQ1 RQ9
          end else if (reqMet && fieldClear && cycleResetClosed &&
                       (autoStart || startEdge)) begin
            state <= CSSC_RUN; // RQ2 RQ5 RQ7
          end
        end
        CSSC_RUN: begin
          cycleCount <= 4'h0; // RQ11
          if (!fieldClear) begin
            state     <= CSSC_ARMED; // RQ6
            autoStart <= 1'b0; // RQ7
            breakSkip <= 1'b1; // RQ7
          end else if (!cycleResetClosed) begin
            state     <= CSSC_HOLD; // RQ3
            autoStart <= 1'b1; // RQ5
          end
        end
        CSSC_HOLD: begin
          cycleCount <= 4'h0; // RQ4
          if (cycleResetClosed) begin
            state <= CSSC_ARMED;
          end
        end
        default: begin
          state <= CSSC_IDLE;
        end
      endcase
    end
  end

  // opens in the same cycle as the cause
  assign safetySwitchingOutput = (state == CSSC_RUN) && fieldClear && cycleResetClosed &&
                                 cyclicActive; // RQ6 RQ3

  //////////////////////////////////////////////////////////////////////////
  // the outputs never stand closed against a cause to open
  chk_out_drop: assert property (@(posedge ref_clk) disable iff (!reset_n) // RQ6
    !fieldClear |-> !safetySwitchingOutput)
    else $error("output on with field broken");
  chk_switch_open: assert property (@(posedge ref_clk) disable iff (!reset_n) // RQ3
    !cycleResetClosed |-> !safetySwitchingOutput)
    else $error("output on with switch open");
  chk_mode_gate: assert property (@(posedge ref_clk) disable iff (!reset_n) // RQ8
    !cyclicActive |-> !safetySwitchingOutput)
    else $error("output on outside cyclic mode");
  chk_mode_clear: assert property (@(posedge ref_clk) disable iff (!reset_n) // RQ8
    !cyclicActive |=> state == CSSC_IDLE && cycleCount == 4'h0)
    else $error("sequence kept outside cyclic mode");

  // counting
  chk_count_req: assert property (@(posedge ref_clk) disable iff (!reset_n) // RQ1
    $rose(safetySwitchingOutput) |-> $past(cycleCount) >= 4'(REQ_CYCLES))
    else $error("release without counted cycles");
  chk_count_cap: assert property (@(posedge ref_clk) disable iff (!reset_n) // RQ1
    cycleCount <= 4'(REQ_CYCLES))
    else $error("count beyond the required number");
  chk_count_step: assert property (@(posedge ref_clk) disable iff (!reset_n) // RQ9
    cycleCount != $past(cycleCount) && cycleCount != 4'h0
    |-> $past(cycleDone) && cycleCount == $past(cycleCount) + 4'h1)
    else $error("count moved without one interruption");
  chk_count_clear: assert property (@(posedge ref_clk) disable iff (!reset_n) // RQ11
    state == CSSC_RUN |=> cycleCount == 4'h0)
    else $error("count kept while running");
  chk_mon_reset: assert property (@(posedge ref_clk) disable iff (!reset_n) // RQ10
    state == CSSC_ARMED && monExpired && cyclicActive |=> cycleCount == 4'h0)
    else $error("timeout kept count");

  // cycle-count reset switch
  chk_hold_nocount: assert property (@(posedge ref_clk) disable iff (!reset_n) // RQ4
    state == CSSC_HOLD |=> cycleCount == 4'h0)
    else $error("counted with switch open");
  chk_lock_nocount: assert property (@(posedge ref_clk) disable iff (!reset_n) // RQ4
    switchLocked |=> cycleCount <= $past(cycleCount))
    else $error("counted while switch locked");
  chk_lock_release: assert property (@(posedge ref_clk) disable iff (!reset_n) // RQ4
    $fell(switchLocked) |-> $past(cycleResetClosed) && $past(openTimer) >= RESET_OPEN_CYC)
    else $error("switch lock released early");
  chk_switch_hold: assert property (@(posedge ref_clk) disable iff (!reset_n) // RQ3
    state == CSSC_RUN && fieldClear && !cycleResetClosed && cyclicActive
    |=> state == CSSC_HOLD && autoStart)
    else $error("no hold when switch opens");

  // release and restart
  chk_start_need: assert property (@(posedge ref_clk) disable iff (!reset_n) // RQ2
    state == CSSC_ARMED && $past(state) == CSSC_ARMED && !autoStart && !startEdge
    |=> state != CSSC_RUN)
    else $error("release without start press");
  chk_auto_release: assert property (@(posedge ref_clk) disable iff (!reset_n) // RQ5
    state == CSSC_ARMED && autoStart && !breakSkip && reqMet && fieldClear &&
    cycleResetClosed && cyclicActive && !monExpired |=> state == CSSC_RUN)
    else $error("no release after switch cycle");
  chk_run_stop: assert property (@(posedge ref_clk) disable iff (!reset_n) // RQ7
    state == CSSC_RUN && !fieldClear && cyclicActive
    |=> state == CSSC_ARMED && !autoStart && breakSkip)
    else $error("no stop on interruption");
  chk_break_skip: assert property (@(posedge ref_clk) disable iff (!reset_n) // RQ7
    state == CSSC_ARMED && breakSkip && cycleDone && cyclicActive |=> cycleCount == 4'h0)
    else $error("stopping interruption was counted");

  // main scenarios
  cov_release: cover property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(safetySwitchingOutput));
  cov_auto: cover property (@(posedge ref_clk) disable iff (!reset_n)
    state == CSSC_ARMED && autoStart ##1 state == CSSC_RUN);
  cov_break: cover property (@(posedge ref_clk) disable iff (!reset_n)
    state == CSSC_RUN && !fieldClear);
  cov_skip: cover property (@(posedge ref_clk) disable iff (!reset_n)
    state == CSSC_ARMED && breakSkip && cycleDone);
  cov_timeout: cover property (@(posedge ref_clk) disable iff (!reset_n)
    state == CSSC_ARMED && monExpired && cycleCount != 4'h0);
endmodule // cyclic_start_safety_control
`default_nettype wire

// ### rtl/cssc_regs.svh
`ifndef CSSC_REGS_SVH
`define CSSC_REGS_SVH
// interruptions needed before a release
`define CSSC_REQ_CYCLES      4'h2
// least open time of the cycle-count reset switch: 30 ms at 100 MHz
`define CSSC_RESET_OPEN_CYC  32'h002dc6c0
// monitoring time between steps: 30 s at 100 MHz
`define CSSC_MONITOR_CYC     32'hb2d05e00
// operating-mode family codes (upper byte of the mode code)
`define CSSC_MODE_FAM_A      8'h66
`define CSSC_MODE_FAM_B      8'hee
`endif

// ### rtl/cssc_pkg.sv
package cssc_pkg;
  typedef enum {
    CSSC_IDLE,
    CSSC_ARMED,
    CSSC_RUN,
    CSSC_HOLD
  } cssc_state_e;
  typedef logic [15:0] cssc_mode_t;
endpackage

// ### tb/cssc_machine_model.sv
`timescale 1ns/100ps
`default_nettype none
module cssc_machine_model #(
  parameter int OPEN_CYC = 25
) (
  input  wire logic ref_clk,
  input  wire logic endMove,
  output var  logic cycleResetClosed
);
  int openLeft = 0;
  ////////////////////////////////////////////////////////////////
  // switch opens at the end of a movement, stays open past the minimum
  always_ff @(posedge ref_clk) begin
    if (endMove) openLeft <= OPEN_CYC;
    else if (openLeft > 0) openLeft <= openLeft - 1;
  end
  always_comb cycleResetClosed = (openLeft == 0);
endmodule // cssc_machine_model
`default_nettype wire

// ### tb/cyclic_start_safety_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module cyclic_start_safety_control_tb;
  import cssc_pkg::*;
  logic       ref_clk;
  logic       reset_n;
  cssc_mode_t modeCode;
  logic       fieldClear;
  logic       startButton;
  logic       endMove;
  logic       out;
  logic       active;
  logic [3:0] cnt;
  wire logic  cycleResetClosed;
  int         fail_count = 0;
  int         n_compared = 0;
  ////////////////////////////////////////////////////////////////
  cyclic_start_safety_control #(.RESET_OPEN_CYC(20), .MONITOR_CYC(500)) dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .modeCode(modeCode),
    .fieldClear(fieldClear), .startButton(startButton),
    .cycleResetClosed(cycleResetClosed), .safetySwitchingOutput(out),
    .cyclicActive(active), .cycleCount(cnt));
  cssc_machine_model #(.OPEN_CYC(25)) machine (
    .ref_clk(ref_clk), .endMove(endMove), .cycleResetClosed(cycleResetClosed));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic intr();
    fieldClear = 1'b0;
    cyc(2);
    fieldClear = 1'b1;
    cyc(2);
  endtask
  task automatic press();
    startButton = 1'b1;
    cyc(2);
    startButton = 1'b0;
    cyc(1);
  endtask
  task automatic t_release();
    intr();
    chk("count", cnt, 4'h1);
    chk("output", out, 4'h0);
    intr();
    chk("count", cnt, 4'h2);
    press();
    chk("output", out, 4'h1);
    $display("test release done");
  endtask
  task automatic t_switch();
    endMove = 1'b1;
    cyc(1);
    endMove = 1'b0;
    chk("output", out, 4'h0);
    cyc(1);
    chk("count", cnt, 4'h0);
    intr();
    intr();
    chk("count", cnt, 4'h0);
    cyc(20);
    intr();
    intr();
    cyc(1);
    chk("output", out, 4'h1);
    $display("test switch done");
  endtask
  task automatic t_break();
    fieldClear = 1'b0;
    #1;
    chk("output", out, 4'h0);
    cyc(1);
    fieldClear = 1'b1;
    cyc(2);
    chk("count", cnt, 4'h0);
    intr();
    intr();
    cyc(2);
    chk("output", out, 4'h0);
    press();
    chk("output", out, 4'h1);
    $display("test break done");
  endtask
  task automatic t_mode();
    modeCode = 16'h8855;
    #1;
    chk("output", out, 4'h0);
    chk("active", active, 4'h0);
    cyc(1);
    modeCode = 16'hee01;
    cyc(1);
    chk("active", active, 4'h1);
    chk("output", out, 4'h0);
    $display("test mode done");
  endtask
  task automatic t_monitor();
    intr();
    chk("count", cnt, 4'h1);
    cyc(480);
    chk("count", cnt, 4'h1);
    cyc(30);
    chk("count", cnt, 4'h0);
    $display("test monitor done");
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    modeCode = 16'h6612;
    fieldClear = 1'b1;
    startButton = 1'b0;
    endMove = 1'b0;
    cyc(4);
    chk("output", out, 4'h0);
    chk("count", cnt, 4'h0);
    reset_n = 1'b1;
    cyc(2);
    t_release();
    t_switch();
    t_break();
    t_mode();
    t_monitor();
    test_done();
  end
  // the tests need about 600 cycles
  initial begin
    #100us;
    fail_count++;
    test_done();
  end
endmodule // cyclic_start_safety_control_tb
`default_nettype wire
